// ### sram_ctrl_pkg.sv
// package: pin timing constants and carrier types for the async sram controller
package sram_ctrl_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 4;
  // least times in ns
  localparam int T_WRITE_PULSE_NS = 9;
  localparam int T_WRITE_FLOAT_NS = 8;
  localparam int T_DATA_SETUP_NS = 6;
  localparam int T_READ_CYCLE_NS = 10;
  localparam int T_CS_ACCESS_NS = 10;
  localparam int T_OE_FLOAT_NS = 8;
  localparam int T_OUT_ACTIVE_NS = 4;
  localparam int T_WRITE_CYCLE_NS = 10;
  // cycle counts, least times rounded up
  localparam int WP_PLAIN_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_OE_SUM_NS = T_WRITE_FLOAT_NS + T_DATA_SETUP_NS;
  localparam int WP_OE_NS = (WP_OE_SUM_NS > T_WRITE_PULSE_NS) ? WP_OE_SUM_NS : T_WRITE_PULSE_NS;
  localparam int WP_OE_CYC = (WP_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (T_WRITE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_ACC_NS = (T_CS_ACCESS_NS > T_READ_CYCLE_NS) ? T_CS_ACCESS_NS : T_READ_CYCLE_NS;
  // one extra cycle so the sample lands after the access time, not on it
  localparam int RD_CYC = (RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int OE_REL_CYC = (T_OE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OUT_ACT_CYC = (T_OUT_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WC_CYC = (T_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_type;

  typedef struct packed {
    logic              cs_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] dq_oe;
  } pins_type;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_SETUP  = 7'h02,
    ST_WSTROBE= 7'h04,
    ST_WEND   = 7'h08,
    ST_READ   = 7'h10,
    ST_RFLOAT = 7'h20,
    ST_GAP    = 7'h40
  } state_type;
endpackage

// ### sram_ctrl.sv
// async 32K x 8 sram controller driving chip select, write strobe, output enable and data pins
`timescale 1ns/1ns
module sram_ctrl
  import sram_ctrl_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              req_valid,
  input  wire req_type           req,
  // keep oe low through writes; costs a longer strobe
  input  wire logic              write_oe_low,
  output logic                   req_ready,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   cs_n,
  output logic                   we_n,
  output logic                   oe_n,
  output logic [ADDR_W-1:0]      addr,
  output logic [DATA_W-1:0]      dq_out,
  output logic [DATA_W-1:0]      dq_oe,
  input  wire logic [DATA_W-1:0] dq_in
);

  state_type         state;
  state_type         next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [CNT_W-1:0]  gap;
  logic [CNT_W-1:0]  next_gap;
  logic              oe_wr;
  logic              next_oe_wr;
  pins_type          pins;
  pins_type          next_pins;
  logic [DATA_W-1:0] next_rd_data;
  logic              next_rd_valid;
  logic              strobe_go;

  assign req_ready = (state == ST_IDLE);
  assign cs_n      = pins.cs_n;
  assign we_n      = pins.we_n;
  assign oe_n      = pins.oe_n;
  assign addr      = pins.addr;
  assign dq_out    = pins.dq_out;
  assign dq_oe     = pins.dq_oe;

  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_oe_wr    = oe_wr;
    next_pins     = pins;
    case (state)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          // address moves only with select or strobe high
          next_pins.addr = req.addr;
          if (req.write)
          begin
            next_oe_wr      = write_oe_low;
            next_pins.oe_n  = ~write_oe_low;
            next_pins.dq_out = req.wdata;
            next_state      = ST_SETUP;
          end
          else
          begin
            next_pins.cs_n = 1'b0;
            next_pins.oe_n = 1'b0;
            next_pins.we_n = 1'b1;
            next_cnt       = CNT_W'(RD_CYC - 1);
            next_state     = ST_READ;
          end
        end
      end
      ST_SETUP:
      begin
        // wait out write spacing, then select and strobe together
        if (strobe_go)
        begin
          next_pins.cs_n = 1'b0;
          next_pins.we_n = 1'b0;
          // with oe high the memory never drives, data may go out at once
          next_pins.dq_oe = oe_wr ? '0 : '1;
          next_cnt        = oe_wr ? CNT_W'(WP_OE_CYC - 1) : CNT_W'(WP_PLAIN_CYC - 1);
          next_state      = ST_WSTROBE;
        end
      end
      ST_WSTROBE:
      begin
        // data enabled only after memory floated
        // counted from the strobe fall, so the data setup before the end keeps its margin
        if (oe_wr && cnt == CNT_W'(WP_OE_CYC - FLOAT_CYC))
          next_pins.dq_oe = '1;
        if (cnt == '0)
        begin
          // strobe and select rise together; data held one more cycle
          next_pins.we_n = 1'b1;
          next_pins.cs_n = 1'b1;
          next_state     = ST_WEND;
        end
        else
          next_cnt = cnt - 1'b1;
      end
      ST_WEND:
      begin
        // release before memory may drive again
        next_pins.dq_oe = '0;
        next_pins.oe_n  = 1'b1;
        next_state      = ST_IDLE;
      end
      ST_READ:
      begin
        if (cnt == '0)
        begin
          next_pins.cs_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_cnt       = CNT_W'(OE_REL_CYC - 1);
          next_state     = ST_RFLOAT;
        end
        else
          next_cnt = cnt - 1'b1;
      end
      ST_RFLOAT:
      begin
        // bus turnaround: memory may drive up to 8 ns after deselect
        if (cnt == '0)
          next_state = ST_IDLE;
        else
          next_cnt = cnt - 1'b1;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state    <= ST_IDLE;
      cnt      <= '0;
      oe_wr    <= 1'b0;
      // a reset during the strobe cuts the write; that byte is then undefined
      pins     <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: '0};
    end
    else
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      oe_wr    <= next_oe_wr;
      pins     <= next_pins;
    end
  end

  // write spacing group: counts down from each strobe start
  assign strobe_go = (gap == '0) || (gap == CNT_W'(1));

  always_comb
  begin
    next_gap = gap;
    if (state == ST_SETUP && strobe_go)
      next_gap = CNT_W'(WC_CYC - 1);
    else if (gap != '0)
      next_gap = gap - 1'b1;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gap <= '0;
    end
    else
    begin
      gap <= next_gap;
    end
  end

  // read capture group; data held until the next read
  always_comb
  begin
    next_rd_data  = rd_data;
    next_rd_valid = 1'b0;
    if (state == ST_READ && cnt == '0)
    begin
      next_rd_data  = dq_in;
      next_rd_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

endmodule

// ### sram_ctrl_asserts.sv
// sram controller pin checker
`timescale 1ns/1ns
module sram_ctrl_asserts
  import sram_ctrl_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              cs_n,
  input wire logic              we_n,
  input wire logic              oe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_addr_move: assert property ($changed(addr) |-> we_n || cs_n) else $error("addr moved");
  a_pulse_min: assert property ($fell(we_n) |-> !we_n [*3]) else $error("short strobe");
  a_pulse_oe: assert property ($fell(we_n) && !oe_n |-> !we_n [*4]) else $error("short oe strobe");
  a_bus_turn: assert property ($fell(we_n) && !oe_n |-> (dq_oe == 8'h00) [*2]) else $error("early drive");
  a_read_we: assert property ($fell(cs_n) && we_n |-> we_n [*3]) else $error("strobe in read");
  a_read_len: assert property ($fell(cs_n) && we_n |-> !cs_n [*4]) else $error("short read");
  a_data_setup: assert property ($rose(we_n) |-> &dq_oe && &$past(dq_oe) && &$past(dq_oe, 2)) else $error("setup");
  a_cs_hold: assert property ($rose(we_n) |-> !$past(cs_n, 3) && addr == $past(addr, 3)) else $error("hold");
  a_end_gap: assert property ($rose(we_n) |-> cs_n ##1 we_n) else $error("end gap");
  c_wr_oe_high: cover property ($fell(we_n) && oe_n);
  c_wr_oe_low: cover property ($fell(we_n) && !oe_n);
  c_read: cover property ($fell(cs_n) && we_n);
endmodule
bind sram_ctrl sram_ctrl_asserts chk_u
(
  .sys_clk (sys_clk),
  .nrst    (nrst),
  .cs_n    (cs_n),
  .we_n    (we_n),
  .oe_n    (oe_n),
  .addr    (addr),
  .dq_oe   (dq_oe)
);

// ### sram_model.sv
// behavioural 32K x 8 async sram
`timescale 1ns/1ns
module sram_model
  import sram_ctrl_pkg::*;
(
  input  wire logic              cs_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic [DATA_W-1:0] dq_oe,
  output logic      [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] q;
  wire               wr = !cs_n && !we_n;
  // turn-on and release at their slowest; a floating bus shows inverted data
  wire #(6,8)        drv = !cs_n && !oe_n && we_n;
  assign #3 q = mem[addr];
  // both sides driving shows as unknown, so a later read fails
  always_comb
  begin
    if (drv && (dq_oe != '0))
      dq_in = 'x;
    else
      dq_in = (dq_oe & dq_out) | (~dq_oe & (drv ? q : ~q));
  end
  always @(negedge wr) mem[addr] = dq_in;
endmodule

// ### sram_ctrl_tb.sv
// bench for the sram controller
`timescale 1ns/1ns
module sram_ctrl_tb
  import sram_ctrl_pkg::*;
;
  logic              sys_clk = 1'h0, nrst = 1'h0, req_valid = 1'h0, write_oe_low = 1'h0;
  req_type           req = '0;
  logic              req_ready, rd_valid, cs_n, we_n, oe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rd_data, dq_out, dq_oe, dq_in;
  int                err_total = 0, n_checks = 0;
  sram_ctrl dut_u
  (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .req_valid    (req_valid),
    .req          (req),
    .write_oe_low (write_oe_low),
    .req_ready    (req_ready),
    .rd_valid     (rd_valid),
    .rd_data      (rd_data),
    .cs_n         (cs_n),
    .we_n         (we_n),
    .oe_n         (oe_n),
    .addr         (addr),
    .dq_out       (dq_out),
    .dq_oe        (dq_oe),
    .dq_in        (dq_in)
  );
  sram_model mem_u
  (
    .cs_n   (cs_n),
    .we_n   (we_n),
    .oe_n   (oe_n),
    .addr   (addr),
    .dq_out (dq_out),
    .dq_oe  (dq_oe),
    .dq_in  (dq_in)
  );
  task automatic chk(input string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic send(input logic w, logic [14:0] a, logic [7:0] d, logic o);
    repeat (20) if (!req_ready) @(negedge sys_clk);
    chk("req_ready", 16'h0001, {15'h0000, req_ready});
    req_valid = 1'h1;
    req = '{w, a, d};
    write_oe_low = o;
    @(negedge sys_clk);
    req_valid = 1'h0;
  endtask
  task automatic rd(input logic [14:0] a, logic [7:0] e);
    send(1'h0, a, 8'h00, 1'h0);
    repeat (8) if (!rd_valid) @(negedge sys_clk);
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
    chk("rd_data", {8'h00, e}, {8'h00, rd_data});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_write_read;
    send(1'h1, 15'h0000, 8'hA5, 1'h0);
    send(1'h1, 15'h7FFF, 8'h5A, 1'h1);
    send(1'h1, 15'h2AAA, 8'h3C, 1'h1);
    send(1'h1, 15'h2AAA, 8'hC3, 1'h0);
    rd(15'h0000, 8'hA5);
    rd(15'h7FFF, 8'h5A);
    rd(15'h2AAA, 8'hC3);
    $display("t_write_read done");
  endtask
  // reset lands while the strobe is low
  task automatic t_abort;
    send(1'h1, 15'h1234, 8'h77, 1'h0);
    repeat (2) @(negedge sys_clk);
    nrst = 1'h0;
    #1 chk("ctl", 16'h0007, {13'h0000, cs_n, we_n, oe_n});
    chk("dq_oe", 16'h0000, {8'h00, dq_oe});
    @(negedge sys_clk);
    nrst = 1'h1;
    rd(15'h7FFF, 8'h5A);
    $display("t_abort done");
  endtask
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    #4000;
    $display("MISMATCH watchdog exp finished got timeout");
    err_total++;
    finish_test;
  end
  initial
  begin
    repeat (12) @(negedge sys_clk);
    nrst = 1'h1;
    @(negedge sys_clk);
    t_write_read;
    t_abort;
    finish_test;
  end
endmodule
